/* File: hdl/sas_sequencer.sv */
// Register file, clocking, power gating and result handling of the converter sequencer.
// Functional notes
// - Produce 10-bit successive approximation results from one of 16 channels.
// - A 4-bit channel_select field in control register picks the channel.
// - Input above upper reference gives all ones, high FFh, low 03h, no flag.
// - Input below lower reference gives zero in both result bytes.
// - Setting converter_on starts continuous back-to-back conversion of selected channel.
// - Each finished conversion sets the done flag and stores its result.
// - Reading result_high_byte clears the done flag. Code: a read in a completion cycle leaves done set.
// - Results are not held; every conversion overwrites both result bytes.
// - Changing channel_select aborts current conversion, clears done, converts new channel.
// - Clearing converter_on powers the converter down and stops conversion.
// - Wait mode has no effect on the converter.
// - Halt disables the converter; a settle time follows wakeup before converting.
// - Analog use of a pin does not stop it being read as logic input.
// - Any control register write clears done; the done bit is read only. Code: a same-channel write in a completion cycle leaves done set.
// - Speed bit picks converter clock: CPU clock over 4 when clear, over 2 set.
// - High byte holds result bits 9:2; low byte holds bits 1:0, rest zero.
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
module sas_sequencer #(
  parameter int RES_BITS      = sas_pkg::RES_BITS,
  parameter int PIN_BITS      = sas_pkg::PIN_BITS,
  parameter int SETTLE_CYCLES = sas_pkg::WAKE_SETTLE_CYC
) (
  // Clock and reset.
  input  wire logic                          clk_i,
  input  wire logic                          resetn_i,
  // Register port.
  input  wire logic [sas_pkg::ADDR_BITS-1:0] addr_i,
  input  wire logic [sas_pkg::DATA_BITS-1:0] wdata_i,
  input  wire logic                          wr_i,
  input  wire logic                          rd_i,
  output logic      [sas_pkg::DATA_BITS-1:0] rdata_o,
  // Analog core.
  input  wire logic                          cmp_i,
  input  wire logic                          over_ref_i,
  input  wire logic                          under_ref_i,
  output logic      [sas_pkg::CHAN_BITS-1:0] channel_select_o,
  output logic      [RES_BITS-1:0]           dac_code_o,
  output logic                               sample_o,
  output logic                               analog_on_o,
  // Power mode.
  input  wire logic                          halt_i,
  // Port pins.
  input  wire logic [PIN_BITS-1:0]           pin_i,
  output logic      [PIN_BITS-1:0]           port_read_o
);

  logic [sas_pkg::CHAN_BITS-1:0] channel_select_q;
  logic                          speed_q;
  logic                          converter_on_q;
  logic                          done_q;
  logic [RES_BITS-1:0]           result_q;
  logic [sas_pkg::DATA_BITS-1:0] rdata_q;
  logic [PIN_BITS-1:0]           port_read_q;
  logic                          analog_on_q;
  logic [1:0]                    div_cnt_q;
  logic                          tick_q;
  logic [15:0]                   settle_cnt_q;
  logic                          halt_q;
  logic                          ctrl_wr;
  logic                          high_rd;
  logic                          chan_change;
  logic                          run;
  logic                          settled;
  logic                          core_done;
  logic [RES_BITS-1:0]           core_result;
  logic [1:0]                    div_last;

  assign ctrl_wr     = wr_i && (addr_i == sas_pkg::OFS_CTRL);
  assign high_rd     = rd_i && (addr_i == sas_pkg::OFS_HIGH);
  assign chan_change = ctrl_wr && (wdata_i[sas_pkg::CHAN_LSB +: sas_pkg::CHAN_BITS]
                                   != channel_select_q);
  assign settled     = (settle_cnt_q == 16'h0000);
  // Only halt, the settle delay after it and the enable bit gate the converter; wait mode is not an input at all.
  assign run         = converter_on_q && !halt_i && settled;
  assign div_last    = speed_q ? sas_pkg::DIV_FAST_LAST : sas_pkg::DIV_SLOW_LAST;

  // Control register fields, written by software.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      channel_select_q <= sas_pkg::CTRL_RESET[sas_pkg::CHAN_LSB +: sas_pkg::CHAN_BITS];
      speed_q          <= sas_pkg::CTRL_RESET[sas_pkg::BIT_SPEED];
      converter_on_q   <= sas_pkg::CTRL_RESET[sas_pkg::BIT_ON];
    end else if (ctrl_wr) begin
      channel_select_q <= wdata_i[sas_pkg::CHAN_LSB +: sas_pkg::CHAN_BITS];
      speed_q          <= wdata_i[sas_pkg::BIT_SPEED];
      converter_on_q   <= wdata_i[sas_pkg::BIT_ON];
    end
  end

  // Converter clock enable: one tick every fourth or every second CPU cycle.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_cnt_q <= 2'h0;
      tick_q    <= 1'b0;
    end else if (!run) begin
      div_cnt_q <= 2'h0;
      tick_q    <= 1'b0;
    end else if (div_cnt_q >= div_last) begin
      div_cnt_q <= 2'h0;
      tick_q    <= 1'b1;
    end else begin
      div_cnt_q <= div_cnt_q + 2'h1;
      tick_q    <= 1'b0;
    end
  end

  // Settling delay after leaving halt.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      halt_q       <= 1'b0;
      settle_cnt_q <= 16'h0000;
    end else begin
      halt_q <= halt_i;
      if (halt_i) begin
        settle_cnt_q <= 16'h0000;
      end else if (halt_q) begin
        settle_cnt_q <= 16'(SETTLE_CYCLES);
      end else if (!settled) begin
        settle_cnt_q <= settle_cnt_q - 16'h0001;
      end
    end
  end

  // Analog power enable follows converter_on and not halt_i, registered; the settle delay in run does not gate it.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      analog_on_q <= 1'b0;
    end else begin
      analog_on_q <= converter_on_q && !halt_i;
    end
  end

  sas_sar_core #(
    .RES_BITS (RES_BITS)
  ) u_core (
    .clk_i      (clk_i),
    .resetn_i   (resetn_i),
    .tick_i     (tick_q),
    .run_i      (run),
    .restart_i  (chan_change),
    .cmp_i      (cmp_i),
    .dac_code_o (dac_code_o),
    .result_o   (core_result),
    .sample_o   (sample_o),
    .done_o     (core_done)
  );

  // Result store, overwritten by every completion not discarded by a channel change, with saturation at the references.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      result_q <= sas_pkg::RESULT_RESET;
    end else if (core_done && !chan_change) begin
      if (over_ref_i) begin
        result_q <= sas_pkg::RESULT_FULL;
      end else if (under_ref_i) begin
        result_q <= sas_pkg::RESULT_ZERO;
      end else begin
        result_q <= core_result;
      end
    end
  end

  // Done flag: a completion wins over a read or same-channel write clear in the same cycle; a channel change discards it.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      done_q <= sas_pkg::CTRL_RESET[sas_pkg::BIT_DONE];
    end else if (core_done && !chan_change) begin
      done_q <= 1'b1;
    end else if (high_rd || ctrl_wr) begin
      done_q <= 1'b0;
    end
  end

  // Read data, valid in the cycle after the read strobe; done is polled, never signalled.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= sas_pkg::RDATA_NONE;
    end else if (rd_i) begin
      case (addr_i)
        sas_pkg::OFS_CTRL: rdata_q <= {done_q, speed_q, converter_on_q, 1'b0,
                                       channel_select_q};
        sas_pkg::OFS_HIGH: rdata_q <= result_q[RES_BITS-1:sas_pkg::HIGH_LSB];
        sas_pkg::OFS_LOW:  rdata_q <= {6'h00, result_q[sas_pkg::HIGH_LSB-1:0]};
        default:           rdata_q <= sas_pkg::RDATA_NONE;
      endcase
    end else begin
      rdata_q <= sas_pkg::RDATA_NONE;
    end
  end

  // Pins stay readable as logic inputs whatever the converter does.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port_read_q <= '0;
    end else begin
      port_read_q <= pin_i;
    end
  end

  assign rdata_o          = rdata_q;
  assign channel_select_o = channel_select_q;
  assign analog_on_o      = analog_on_q;
  assign port_read_o      = port_read_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  a_done_sets: assert property (
    core_done && !chan_change |=> done_q)
    else $error("done flag not set after completion");

  a_high_read_clear: assert property (
    high_rd && !core_done |=> !done_q)
    else $error("reading high byte did not clear done");

  a_write_clear: assert property (
    ctrl_wr && !core_done |=> !done_q)
    else $error("control write did not clear done");

  a_chan_restart: assert property (
    chan_change && converter_on_q && !halt_i && settled |=> sample_o && !done_q)
    else $error("channel change did not restart conversion");

  a_result_store: assert property (
    core_done && !chan_change && !over_ref_i && !under_ref_i |=>
      result_q == $past(core_result))
    else $error("result not overwritten by completion");

  a_sat_high: assert property (
    core_done && !chan_change && over_ref_i |=> result_q == sas_pkg::RESULT_FULL)
    else $error("over-range result not all ones");

  a_sat_low: assert property (
    core_done && !chan_change && !over_ref_i && under_ref_i |=>
      result_q == sas_pkg::RESULT_ZERO)
    else $error("under-range result not zero");

  a_high_byte: assert property (
    high_rd |=> rdata_o == $past(result_q[RES_BITS-1:sas_pkg::HIGH_LSB]))
    else $error("high byte does not show result bits 9 to 2");

  a_low_upper: assert property (
    rd_i && addr_i == sas_pkg::OFS_LOW |=> rdata_o[7:2] == 6'h00)
    else $error("low byte upper bits not zero");

  a_halt_off: assert property (
    halt_i |=> !analog_on_o && !tick_q)
    else $error("converter active during halt");

  a_off_stops: assert property (
    !converter_on_q |=> !analog_on_o && !sample_o)
    else $error("converter active while switched off");

  a_tick_gap: assert property (
    tick_q |=> !tick_q)
    else $error("converter tick faster than half the CPU clock");

  a_slow_rate: assert property (
    tick_q && !speed_q && run ##1 (!speed_q && run) [*3] |=> tick_q)
    else $error("slow converter tick not every fourth cycle");

  a_pin_follow: assert property (
    1'b1 |=> port_read_o == $past(pin_i))
    else $error("port read does not follow pins");

  c_done_seen: cover property (core_done && !chan_change ##[1:4] high_rd);
  c_chan_abort: cover property (chan_change && sample_o == 1'b0 && converter_on_q);
  c_wake_settle: cover property ($fell(halt_i) ##[1:60] settled && converter_on_q);
  c_saturated: cover property (core_done && over_ref_i);

endmodule

/* File: hdl/sas_pkg.sv */
// Shared constants and types for the successive approximation converter sequencer.
package sas_pkg;

  localparam int RES_BITS  = 10;
  localparam int CHAN_BITS = 4;
  localparam int ADDR_BITS = 8;
  localparam int DATA_BITS = 8;
  localparam int PIN_BITS  = 16;

  localparam logic [7:0] OFS_CTRL = 8'h70;
  localparam logic [7:0] OFS_HIGH = 8'h71;
  localparam logic [7:0] OFS_LOW  = 8'h72;

  localparam int BIT_DONE  = 7;
  localparam int BIT_SPEED = 6;
  localparam int BIT_ON    = 5;
  localparam int BIT_RSVD  = 4;
  localparam int CHAN_LSB  = 0;
  localparam int HIGH_LSB  = 2;

  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  localparam logic [9:0] RESULT_FULL  = 10'h3ff;
  localparam logic [9:0] RESULT_ZERO  = 10'h000;
  localparam logic [7:0] RDATA_NONE   = 8'h00;

  localparam logic [1:0] DIV_SLOW_LAST = 2'h3;
  localparam logic [1:0] DIV_FAST_LAST = 2'h1;

  localparam int CLK_PERIOD_PS   = 25000;
  localparam int WAKE_SETTLE_NS  = 1000;
  localparam int WAKE_SETTLE_CYC = (WAKE_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [1:0] {
    SAS_IDLE   = 2'b00,
    SAS_SAMPLE = 2'b01,
    SAS_TRIAL  = 2'b10
  } sas_core_state_t;

endpackage

/* File: hdl/sas_sar_core.sv */
// Successive approximation bit trial engine with continuous restart.
`timescale 1ns/10ps
module sas_sar_core #(
  parameter int RES_BITS = sas_pkg::RES_BITS
) (
  // Clock and reset.
  input  wire logic                clk_i,
  input  wire logic                resetn_i,
  // Control.
  input  wire logic                tick_i,
  input  wire logic                run_i,
  input  wire logic                restart_i,
  // Analog comparator, high when the input is at or above the trial code.
  input  wire logic                cmp_i,
  // Conversion outputs.
  output logic [RES_BITS-1:0]      dac_code_o,
  output logic [RES_BITS-1:0]      result_o,
  output logic                     sample_o,
  output logic                     done_o
);

  sas_pkg::sas_core_state_t state_q;
  logic [RES_BITS-1:0]      code_q;
  logic [RES_BITS-1:0]      mask_q;
  logic [RES_BITS-1:0]      result_q;
  logic                     sample_q;
  logic                     done_q;
  logic [RES_BITS-1:0]      trial;
  logic [RES_BITS-1:0]      top_bit;

  assign top_bit = {1'b1, {(RES_BITS-1){1'b0}}};
  assign trial   = cmp_i ? code_q : (code_q & ~mask_q);

  // Sample, then resolve one bit per converter tick, then start again.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q  <= sas_pkg::SAS_IDLE;
      code_q   <= sas_pkg::RESULT_RESET;
      mask_q   <= sas_pkg::RESULT_RESET;
      result_q <= sas_pkg::RESULT_RESET;
      sample_q <= 1'b0;
      done_q   <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (!run_i) begin
        state_q  <= sas_pkg::SAS_IDLE;
        sample_q <= 1'b0;
        code_q   <= sas_pkg::RESULT_RESET;
      end else if (restart_i || state_q == sas_pkg::SAS_IDLE) begin
        state_q  <= sas_pkg::SAS_SAMPLE;
        sample_q <= 1'b1;
        code_q   <= sas_pkg::RESULT_RESET;
      end else if (tick_i) begin
        case (state_q)
          sas_pkg::SAS_SAMPLE: begin
            sample_q <= 1'b0;
            mask_q   <= top_bit;
            code_q   <= top_bit;
            state_q  <= sas_pkg::SAS_TRIAL;
          end
          sas_pkg::SAS_TRIAL: begin
            if (mask_q[0]) begin
              result_q <= trial;
              done_q   <= 1'b1;
              state_q  <= sas_pkg::SAS_SAMPLE;
              sample_q <= 1'b1;
              code_q   <= sas_pkg::RESULT_RESET;
            end else begin
              code_q <= trial | (mask_q >> 1);
              mask_q <= mask_q >> 1;
            end
          end
          default: begin
            state_q <= sas_pkg::SAS_IDLE;
          end
        endcase
      end
    end
  end

  assign dac_code_o = code_q;
  assign result_o   = result_q;
  assign sample_o   = sample_q;
  assign done_o     = done_q;

endmodule

/* File: tb/sas_analog_model.sv */
// Behavioural analog core with a level per channel, shifted by the bench offset, and a comparator.
`timescale 1ns/10ps
module sas_analog_model (
  // Clock.
  input  wire logic       clk_i,
  // Converter side.
  input  wire logic [3:0] channel_select_i,
  input  wire logic [9:0] dac_code_i,
  input  wire logic       analog_on_i,
  // Level shift set by the bench.
  input  wire logic [9:0] offset_i,
  // Comparator and reference flags.
  output logic            cmp_o,
  output logic            over_ref_o,
  output logic            under_ref_o
);
  logic [9:0] level;
  logic       tgl_q = 1'b0;

  always @(posedge clk_i) begin
    tgl_q <= ~tgl_q;
  end

  // A powered-down comparator gives a toggling level, never a steady one.
  always_comb begin
    level = channel_select_i * 10'h041 + 10'h00a + offset_i;
    over_ref_o = analog_on_i && (channel_select_i == 4'hf);
    under_ref_o = analog_on_i && (channel_select_i == 4'he);
    if (!analog_on_i) begin
      cmp_o = tgl_q;
    end else begin
      cmp_o = (level >= dac_code_i);
    end
  end
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the converter sequencer.
`timescale 1ns/10ps
module tb_top;
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        halt_i = 1'b0;
  logic [15:0] pin_i = 16'h0000;
  logic [9:0]  offset = 10'h000;
  logic [7:0]  rdata_o;
  logic        cmp_i;
  logic        over_ref_i;
  logic        under_ref_i;
  logic        sample_o;
  logic        analog_on_o;
  logic [3:0]  channel_select_o;
  logic [9:0]  dac_code_o;
  logic [15:0] port_read_o;
  logic [7:0]  d;
  logic [7:0]  lo;
  int          mismatches = 0;
  int          n_tests = 0;

  always #12.5 clk_i = ~clk_i;

  sas_sequencer #(.SETTLE_CYCLES(2)) u_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cmp_i(cmp_i),
    .over_ref_i(over_ref_i), .under_ref_i(under_ref_i),
    .channel_select_o(channel_select_o), .dac_code_o(dac_code_o),
    .sample_o(sample_o), .analog_on_o(analog_on_o), .halt_i(halt_i),
    .pin_i(pin_i), .port_read_o(port_read_o)
  );

  sas_analog_model u_core (
    .clk_i(clk_i), .channel_select_i(channel_select_o), .dac_code_i(dac_code_o),
    .analog_on_i(analog_on_o), .offset_i(offset), .cmp_o(cmp_i),
    .over_ref_o(over_ref_i), .under_ref_o(under_ref_i)
  );

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask

  task automatic wait_done();
    for (int i = 0; i < 100; i++) begin
      rd(sas_pkg::OFS_CTRL, d);
      if (d[7] === 1'b1) return;
    end
    check("done flag", {15'h0000, d[7]}, 16'h0001);
    wrap_up();
  endtask

  function automatic logic [9:0] expect_res(input logic [3:0] ch);
    if (ch == 4'hf) return 10'h3ff;
    if (ch == 4'he) return 10'h000;
    return ch * 10'h041 + 10'h00a + offset;
  endfunction

  // Low byte first, then the high byte, as polling software does.
  task automatic read_result(input logic [3:0] ch);
    rd(sas_pkg::OFS_LOW, lo);
    rd(sas_pkg::OFS_HIGH, d);
    check("low byte pad", {10'h000, lo[7:2]}, 16'h0000);
    check("result", {6'h00, d, lo[1:0]}, {6'h00, expect_res(ch)});
    rd(sas_pkg::OFS_CTRL, d);
    check("done after high read", {15'h0000, d[7]}, 16'h0000);
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      rd(8'h70 + a[7:0], d);
      check("reset value", {8'h00, d}, 16'h0000);
    end
    wr(sas_pkg::OFS_CTRL, 8'h90);
    rd(sas_pkg::OFS_CTRL, d);
    check("ctrl fixed bits", {8'h00, d}, 16'h0000);
    @(posedge clk_i);
    pin_i <= 16'ha5c3;
    repeat (2) @(posedge clk_i);
    #1 check("port read", port_read_o, 16'ha5c3);
    $display("test registers done");
    for (int c = 0; c < 16; c++) begin
      wr(sas_pkg::OFS_CTRL, {2'b00, 1'b1, 1'b0, c[3:0]} | {1'b0, c[0], 6'h00});
      #1 check("channel select", {12'h000, channel_select_o}, {12'h000, c[3:0]});
      repeat (30) @(posedge clk_i);
      rd(sas_pkg::OFS_CTRL, d);
      check("done by divider", {15'h0000, d[7]}, {15'h0000, c[0]});
      wait_done();
      check("analog power", {15'h0000, analog_on_o}, 16'h0001);
      read_result(c[3:0]);
    end
    $display("test channels done");
    wr(sas_pkg::OFS_CTRL, 8'h23);
    wait_done();
    read_result(4'h3);
    @(posedge clk_i);
    offset <= 10'h040;
    wait_done();
    rd(sas_pkg::OFS_HIGH, d);
    rd(sas_pkg::OFS_CTRL, d);
    check("done after high only", {15'h0000, d[7]}, 16'h0000);
    wait_done();
    read_result(4'h3);
    wait_done();
    wr(sas_pkg::OFS_CTRL, 8'h23);
    rd(sas_pkg::OFS_CTRL, d);
    check("done after same write", {8'h00, d}, 16'h0023);
    wait_done();
    wr(sas_pkg::OFS_CTRL, 8'h27);
    #1 check("sample on restart", {15'h0000, sample_o}, 16'h0001);
    rd(sas_pkg::OFS_CTRL, d);
    check("done after channel change", {8'h00, d}, 16'h0027);
    wait_done();
    read_result(4'h7);
    $display("test restart done");
    wr(sas_pkg::OFS_CTRL, 8'h07);
    repeat (3) @(posedge clk_i);
    #1 check("power off", {15'h0000, analog_on_o}, 16'h0000);
    check("sample when off", {15'h0000, sample_o}, 16'h0000);
    repeat (100) @(posedge clk_i);
    rd(sas_pkg::OFS_CTRL, d);
    check("no done when off", {8'h00, d}, 16'h0007);
    wr(sas_pkg::OFS_CTRL, 8'h27);
    halt_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1 check("power in halt", {15'h0000, analog_on_o}, 16'h0000);
    repeat (100) @(posedge clk_i);
    rd(sas_pkg::OFS_CTRL, d);
    check("no done in halt", {8'h00, d}, 16'h0027);
    @(posedge clk_i);
    halt_i <= 1'b0;
    wait_done();
    read_result(4'h7);
    $display("test power done");
    wrap_up();
  end
endmodule
